// *** dv/rdm_monitor_properties.sv ***
/* rdm_monitor_properties: port-level checks of rdm_monitor_top.
   assumes: bound to rdm_monitor_top; pointers steady around an align. */
module rdm_monitor_properties
  import rdm_pkg::*;
(
  input wire logic              sys_clk_in,     // clock
  input wire logic              sys_rst_in,     // reset
  input wire logic              psel_in,        // apb
  input wire logic              penable_in,     // apb
  input wire logic              pwrite_in,      // apb
  input wire logic [APB_AW-1:0] paddr_in,       // apb
  input wire logic [31:0]       pwdata_in,      // apb
  input wire logic [3:0]        pstrb_in,       // apb
  input wire logic [31:0]       prdata_out,     // apb
  input wire logic              pready_out,     // apb
  input wire logic              pslverr_out,    // apb
  input wire rdm_rx_bit_t       rx_bit_in,      // rx bits
  input wire rdm_ptr_pair_t     rx_ptrs_in,     // rx pointers
  input wire rdm_ptr_pair_t     tx_ptrs_in,     // tx pointers
  input wire rdm_align_cmd_t    rx_align_out,   // rx reload
  input wire rdm_align_cmd_t    tx_align_out,   // tx reload
  input wire logic [SEL_W-1:0]  rx_sel_out,     // select
  input wire logic              mon_update_out  // octet loaded
);
  logic       rx_q, tx_q, cwr, crd, mrd, rxr, txr, oct;
  logic [7:0] pos_q, sh_q, mon_q, cur;
  logic [8:0] rsep, tsep;
  wire        acc = psel_in & penable_in & pready_out;
  assign cwr = acc & pwrite_in & pstrb_in[0] & (paddr_in == CTRL_ADDR);
  assign crd = acc & ~pwrite_in & (paddr_in == CTRL_ADDR);
  assign mrd = acc & ~pwrite_in & (paddr_in == MON_ADDR);
  assign rxr = cwr & pwdata_in[RX_ALIGN_BIT] & ~rx_q;
  assign txr = cwr & pwdata_in[TX_ALIGN_BIT] & ~tx_q;
  assign rsep = rx_ptrs_in.wr_ptr - rx_ptrs_in.rd_ptr;
  assign tsep = tx_ptrs_in.wr_ptr - tx_ptrs_in.rd_ptr;
  assign cur = rx_bit_in.frame_start ? POS_FIRST : pos_q;
  assign oct = rx_bit_in.valid & (cur == {rx_sel_out, SLOT_LAST_BIT});
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_q <= 1'b0;
      tx_q <= 1'b0;
    end else if (cwr) begin
      rx_q <= pwdata_in[RX_ALIGN_BIT];
      tx_q <= pwdata_in[TX_ALIGN_BIT];
    end
  end
  // shadow of the received octet, first bit ends up in bit 7
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pos_q <= POS_FIRST;
      sh_q  <= 8'h00;
      mon_q <= MON_RESET;
    end else if (rx_bit_in.valid) begin
      pos_q <= cur + POS_STEP;
      sh_q  <= {sh_q[6:0], rx_bit_in.data};
      if (oct) mon_q <= {sh_q[6:0], rx_bit_in.data};
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_RX_LOAD: assert property (rxr && rsep < HALF_FRAME_SEP |-> ##3
    rx_align_out.load &&
    rx_align_out.rd_ptr == rdm_ptr_t'(rx_ptrs_in.wr_ptr - HALF_FRAME_SEP))
    else $error("rx align did not reload");
  AST_TX_LOAD: assert property (txr && tsep < HALF_FRAME_SEP |-> ##3
    tx_align_out.load &&
    tx_align_out.rd_ptr == rdm_ptr_t'(tx_ptrs_in.wr_ptr - HALF_FRAME_SEP))
    else $error("tx align did not reload");
  AST_RX_SKIP: assert property (rxr && rsep >= HALF_FRAME_SEP |->
    ##1 (!rx_align_out.load)[*4]) else $error("rx align acted needlessly");
  AST_TX_SKIP: assert property (txr && tsep >= HALF_FRAME_SEP |->
    ##1 (!tx_align_out.load)[*4]) else $error("tx align acted needlessly");
  AST_RX_CAUSE: assert property (rx_align_out.load |-> $past(rxr, 3))
    else $error("rx reload without a new rising request");
  AST_TX_CAUSE: assert property (tx_align_out.load |-> $past(txr, 3))
    else $error("tx reload without a new rising request");
  // select reaches its output flop one cycle after the control register
  AST_SEL_COPY: assert property (cwr |-> ##2
    rx_sel_out == $past(pwdata_in[SEL_MSB:SEL_LSB], 2))
    else $error("select output not updated");
  AST_CTRL_READ: assert property (crd |-> prdata_out ==
    {25'h0, rx_q, tx_q, rx_sel_out}) else $error("control read wrong");
  AST_MON_UPDATE: assert property (mon_update_out == $past(oct))
    else $error("monitor update at wrong bit");
  AST_MON_READ: assert property (mrd |-> prdata_out == {24'h0, mon_q})
    else $error("monitor read wrong");
endmodule : rdm_monitor_properties

bind rdm_monitor_top rdm_monitor_properties i_rdm_monitor_properties (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .rx_bit_in(rx_bit_in), .rx_ptrs_in(rx_ptrs_in), .tx_ptrs_in(tx_ptrs_in),
  .rx_align_out(rx_align_out), .tx_align_out(tx_align_out),
  .rx_sel_out(rx_sel_out), .mon_update_out(mon_update_out));

// *** dv/rdm_monitor_top_tb_top.sv ***
/* rdm_monitor_top_tb_top: self-checking bench of rdm_monitor_top.
   assumes: apb answers with a bounded wait; one clock of 125 mhz. */
module rdm_monitor_top_tb_top
  import rdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk, rst, psel, pen, pwr, pready, pslverr, upd;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata;
  logic [3:0]     pstrb;
  logic [4:0]     sel;
  rdm_rx_bit_t    rxb;
  rdm_ptr_pair_t  rxp, txp;
  rdm_align_cmd_t rxa, txa;
  int             failures, checked, upd_cnt;

  rdm_monitor_top i_rdm_monitor_top (
    .sys_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rx_bit_in(rxb), .rx_ptrs_in(rxp),
    .tx_ptrs_in(txp), .rx_align_out(rxa), .tx_align_out(txa),
    .rx_sel_out(sel), .mon_update_out(upd));

  always #4 clk = ~clk;
  always @(negedge clk) upd_cnt += int'(upd === 1'b1);

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    apb(1'b0, CTRL_ADDR, 32'h0, r, e);
    chk("ctrl reset", {24'h0, CTRL_RESET}, r);
    apb(1'b0, MON_ADDR, 32'h0, r, e);
    chk("mon reset", {24'h0, MON_RESET}, r);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    // lane 0 strobe low: the write must store nothing
    pstrb <= 4'h0;
    apb(1'b1, CTRL_ADDR, 32'h1f, r, e);
    pstrb <= 4'hf;
    apb(1'b0, CTRL_ADDR, 32'h0, r, e);
    chk("masked write", {24'h0, CTRL_RESET}, r);
  endtask : t_reset

  // clear, set, then set again without clearing: only the first acts
  task automatic t_align(input logic tx, input logic [8:0] w,
                         input logic [8:0] rd, input logic ld);
    logic [31:0] r, v;
    logic        e;
    logic [8:0]  rp, ex;
    int          c;
    int          st;
    ex = w - HALF_FRAME_SEP;
    v = tx ? 32'h20 : 32'h40;
    if (tx) txp <= '{wr_ptr: w, rd_ptr: rd};
    else rxp <= '{wr_ptr: w, rd_ptr: rd};
    // align bits toggled only after reset, with the clock long running
    apb(1'b1, CTRL_ADDR, 32'h0, r, e);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, CTRL_ADDR, v, r, e);
      c = 0;
      repeat (6) begin
        @(posedge clk);
        if ((tx ? txa.load : rxa.load) === 1'b1) begin
          c++;
          rp = tx ? txa.rd_ptr : rxa.rd_ptr;
        end
      end
      chk("load count", (k == 0) ? {31'h0, ld} : 32'h0, c);
      if (k == 0 && ld) chk("new rd ptr", {23'h0, ex}, {23'h0, rp});
    end
    st = ld ? (tx ? ST_TX_DONE_BIT : ST_RX_DONE_BIT)
            : (tx ? ST_TX_SKIP_BIT : ST_RX_SKIP_BIT);
    apb(1'b0, STAT_ADDR, 32'h0, r, e);
    chk("status", 32'h1 << st, r);
    apb(1'b1, STAT_ADDR, 32'h0000_003f, r, e);
    apb(1'b0, STAT_ADDR, 32'h0, r, e);
    chk("status clear", {26'h0, STAT_RESET}, r);
  endtask : t_align

  task automatic t_mon(input logic [4:0] s);
    logic [31:0] r;
    logic        e;
    logic [7:0]  o;
    apb(1'b1, CTRL_ADDR, {27'h0, s}, r, e);
    apb(1'b0, CTRL_ADDR, 32'h0, r, e);
    chk("select", {27'h0, s}, r);
    upd_cnt = 0;
    for (int i = 0; i < 256; i++) begin
      o = 8'(i / 8) ^ 8'h5a;
      @(posedge clk);
      rxb <= '{valid: 1'b1, data: o[7 - i % 8], frame_start: i == 0};
    end
    @(posedge clk);
    rxb <= '0;
    repeat (3) @(posedge clk);
    chk("updates", 32'h1, upd_cnt);
    apb(1'b1, MON_ADDR, 32'hff, r, e);
    apb(1'b0, MON_ADDR, 32'h0, r, e);
    chk("octet", {24'h0, {3'h0, s} ^ 8'h5a}, r);
  endtask : t_mon

  initial begin
    clk = 0;
    rst = 1;
    {psel, pen, pwr, paddr, pwdata, rxb, rxp, txp} = '0;
    pstrb = 4'hf;
    repeat (5) @(posedge clk);
    rst <= 0;
    t_reset();
    t_align(1'b0, 9'h07f, 9'h000, 1'b1);
    t_align(1'b0, 9'h080, 9'h000, 1'b0);
    t_align(1'b0, 9'h000, 9'h190, 1'b1);
    t_align(1'b1, 9'h07f, 9'h000, 1'b1);
    t_align(1'b1, 9'h1ff, 9'h17f, 1'b0);
    t_mon(5'h00);
    t_mon(5'h0e);
    t_mon(5'h1f);
    give_verdict();
  end

  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule : rdm_monitor_top_tb_top

// *** src/rdm_es_align_unit.sv ***
/*
  rdm_es_align_unit: one elastic store align engine.
  assumes: pointers are sampled synchronous to sys_clk_in; the store
  loads the new read pointer on the cycle that load is high.
*/
module rdm_es_align_unit
  import rdm_pkg::*;
(
  input  wire logic           sys_clk_in,   // system clock
  input  wire logic           sys_rst_in,   // sync reset, active high
  input  wire logic           request_in,   // align control bit level
  input  wire rdm_ptr_pair_t  ptrs_in,      // store write/read pointers
  output rdm_align_cmd_t      cmd_out,      // read pointer reload
  output logic                done_out,     // pulse: pointers moved
  output logic                skip_out      // pulse: no action needed
);

  logic      request_prev_q;
  logic      rise;
  rdm_ptr_t  sep;

  // only a fresh zero-to-one change counts; a held bit does nothing
  assign rise = request_in & ~request_prev_q;
  assign sep  = rdm_ptr_t'(ptrs_in.wr_ptr - ptrs_in.rd_ptr);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      request_prev_q <= 1'b0;
    end else begin
      request_prev_q <= request_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cmd_out  <= '0;
      done_out <= 1'b0;
      skip_out <= 1'b0;
    end else begin
      cmd_out.load   <= 1'b0;
      cmd_out.rd_ptr <= rdm_ptr_t'(ptrs_in.wr_ptr - HALF_FRAME_SEP);
      done_out       <= 1'b0;
      skip_out       <= 1'b0;
      if (rise) begin
        if (sep < HALF_FRAME_SEP) begin
          // reload corrupts data in flight through the store
          cmd_out.load <= 1'b1;
          done_out     <= 1'b1;
        end else begin
          skip_out     <= 1'b1;
        end
      end
    end
  end

endmodule : rdm_es_align_unit

// *** src/rdm_monitor_top.sv ***
/*
  rdm_monitor_top: apb register bank with elastic store align commands
  and the receive channel octet monitor.
  assumes: receive bits arrive as strobes synchronous to sys_clk_in,
  msb of each timeslot first, with a marker on the first frame bit;
  both elastic stores present pointers in the sys_clk_in domain.
*/
// The APB slave port was chosen for this implementation.
module rdm_monitor_top
  import rdm_pkg::*;
(
  input  wire logic               sys_clk_in,     // system clock
  input  wire logic               sys_rst_in,     // sync reset, high
  input  wire logic               psel_in,        // apb select
  input  wire logic               penable_in,     // apb enable
  input  wire logic               pwrite_in,      // apb direction
  input  wire logic [APB_AW-1:0]  paddr_in,       // apb byte address
  input  wire logic [31:0]        pwdata_in,      // apb write data
  input  wire logic [3:0]         pstrb_in,       // apb byte strobes
  output logic [31:0]             prdata_out,     // apb read data
  output logic                    pready_out,     // apb ready
  output logic                    pslverr_out,    // apb error
  input  wire rdm_rx_bit_t        rx_bit_in,      // receive bit strobe
  input  wire rdm_ptr_pair_t      rx_ptrs_in,     // rx store pointers
  input  wire rdm_ptr_pair_t      tx_ptrs_in,     // tx store pointers
  output rdm_align_cmd_t          rx_align_out,   // rx pointer reload
  output rdm_align_cmd_t          tx_align_out,   // tx pointer reload
  output logic [SEL_W-1:0]        rx_sel_out,     // selected timeslot
  output logic                    mon_update_out  // pulse: octet loaded
);

  rdm_apb_state_t     apb_state_q;
  logic [7:0]         ctrl_q;
  logic [7:0]         mon_q;
  logic [ST_W-1:0]    stat_q;
  logic [ST_W-1:0]    stat_set;
  logic [ST_W-1:0]    stat_clr;
  logic [7:0]         shift_q;
  logic [POS_W-1:0]   bit_pos_q;
  logic [POS_W-1:0]   cur_pos;
  logic [SEL_W-1:0]   cur_slot;
  logic [2:0]         cur_bit;
  logic               octet_hit;
  logic               slip;
  logic               commit;
  logic               wr_commit;
  logic               ctrl_hit;
  logic               mon_hit;
  logic               stat_hit;
  logic               addr_ok;
  logic [31:0]        rd_mux;
  logic               rx_done;
  logic               rx_skip;
  logic               tx_done;
  logic               tx_skip;
  rdm_align_cmd_t     rx_cmd;
  rdm_align_cmd_t     tx_cmd;

  // address decode; misaligned or other addresses answer with slverr
  assign ctrl_hit = (paddr_in == CTRL_ADDR);
  assign mon_hit  = (paddr_in == MON_ADDR);
  assign stat_hit = (paddr_in == STAT_ADDR);
  assign addr_ok  = ctrl_hit | mon_hit | stat_hit;

  // a transfer completes on the edge where pready is seen high
  assign commit    = (apb_state_q == APB_RESP) & psel_in & penable_in;
  assign wr_commit = commit & pwrite_in & pstrb_in[0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ctrl_hit) begin
      rd_mux[7:0] = ctrl_q;
    end else if (mon_hit) begin
      rd_mux[7:0] = mon_q;
    end else if (stat_hit) begin
      rd_mux[ST_W-1:0] = stat_q;
    end
  end

  // one wait state: setup, access, then ready in the next cycle
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      apb_state_q <= APB_IDLE;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      case (apb_state_q)
        APB_IDLE: begin
          if (psel_in & penable_in) begin
            apb_state_q <= APB_RESP;
            pready_out  <= 1'b1;
            pslverr_out <= ~addr_ok;
            prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_mux;
          end
        end
        APB_RESP: begin
          apb_state_q <= APB_IDLE;
          pready_out  <= 1'b0;
          pslverr_out <= 1'b0;
          prdata_out  <= 32'h0000_0000;
        end
        default: begin
          apb_state_q <= APB_IDLE;
          pready_out  <= 1'b0;
          pslverr_out <= 1'b0;
          prdata_out  <= 32'h0000_0000;
        end
      endcase
    end
  end

  // control register; the unassigned top bit is held at zero, so a
  // careless write there cannot leave a stale one behind
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_commit & ctrl_hit) begin
      ctrl_q                <= pwdata_in[7:0];
      ctrl_q[CTRL_RSVD_BIT] <= 1'b0;
    end
  end

  // software may only toggle the align bits once the system clocks
  // are stable; the engines trust the pointers they are handed
  rdm_es_align_unit u_rx_align (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .request_in (ctrl_q[RX_ALIGN_BIT]),
    .ptrs_in    (rx_ptrs_in),
    .cmd_out    (rx_cmd),
    .done_out   (rx_done),
    .skip_out   (rx_skip)
  );

  rdm_es_align_unit u_tx_align (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .request_in (ctrl_q[TX_ALIGN_BIT]),
    .ptrs_in    (tx_ptrs_in),
    .cmd_out    (tx_cmd),
    .done_out   (tx_done),
    .skip_out   (tx_skip)
  );

  // reload commands leave through one more flop so every output is
  // registered at the top; the store sees load one cycle later
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_align_out <= '0;
      tx_align_out <= '0;
    end else begin
      rx_align_out <= rx_cmd;
      tx_align_out <= tx_cmd;
    end
  end

  // receive bit position within the frame; the marker restarts it
  assign cur_pos  = rx_bit_in.frame_start ? POS_FIRST : bit_pos_q;
  assign cur_slot = cur_pos[POS_W-1:3];
  assign cur_bit  = cur_pos[2:0];
  // the select value is the timeslot index, channel number minus one
  assign octet_hit = rx_bit_in.valid & (cur_bit == SLOT_LAST_BIT) &
                     (cur_slot == ctrl_q[SEL_MSB:SEL_LSB]);
  assign slip = rx_bit_in.valid & rx_bit_in.frame_start &
                (bit_pos_q != POS_FIRST);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      bit_pos_q <= POS_FIRST;
      shift_q   <= 8'h00;
    end else if (rx_bit_in.valid) begin
      bit_pos_q <= POS_W'(cur_pos + POS_STEP);
      shift_q   <= {shift_q[6:0], rx_bit_in.data};
    end
  end

  // the octet is taken whole at its last bit, once per frame, so a
  // reader never sees half of one slot and half of the next
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mon_q          <= MON_RESET;
      mon_update_out <= 1'b0;
    end else begin
      mon_update_out <= octet_hit;
      if (octet_hit) begin
        mon_q <= {shift_q[6:0], rx_bit_in.data};
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_sel_out <= '0;
    end else begin
      rx_sel_out <= ctrl_q[SEL_MSB:SEL_LSB];
    end
  end

  // sticky status; a new event in the clearing cycle survives
  always_comb begin
    stat_set                 = '0;
    stat_set[ST_RX_DONE_BIT] = rx_done;
    stat_set[ST_RX_SKIP_BIT] = rx_skip;
    stat_set[ST_TX_DONE_BIT] = tx_done;
    stat_set[ST_TX_SKIP_BIT] = tx_skip;
    stat_set[ST_MON_NEW_BIT] = octet_hit;
    stat_set[ST_SLIP_BIT]    = slip;
    stat_clr = (wr_commit & stat_hit) ? pwdata_in[ST_W-1:0] : '0;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      stat_q <= STAT_RESET;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end

endmodule : rdm_monitor_top

// *** src/rdm_pkg.sv ***
/*
  rdm_pkg: shared constants and carrier types of the receive channel
  monitor and elastic store align block.
  assumes: one 125 mhz system clock; 32-bit apb; 256-bit e1 frames.
*/
package rdm_pkg;

  // register indexes; byte address is four times the index
  localparam logic [7:0]  CTRL_IDX        = 8'haa;
  localparam logic [7:0]  MON_IDX         = 8'hab;
  localparam logic [7:0]  STAT_IDX        = 8'hac;
  localparam int unsigned APB_AW          = 12;
  localparam logic [11:0] CTRL_ADDR       = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] MON_ADDR        = {2'h0, MON_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR       = {2'h0, STAT_IDX, 2'h0};

  // control register fields
  localparam int unsigned CTRL_RSVD_BIT   = 7;
  localparam int unsigned RX_ALIGN_BIT    = 6;
  localparam int unsigned TX_ALIGN_BIT    = 5;
  localparam int unsigned SEL_MSB         = 4;
  localparam int unsigned SEL_LSB         = 0;
  localparam int unsigned SEL_W           = SEL_MSB - SEL_LSB + 1;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  MON_RESET       = 8'h00;

  // status register fields (write one to clear)
  localparam int unsigned ST_RX_DONE_BIT  = 0;
  localparam int unsigned ST_RX_SKIP_BIT  = 1;
  localparam int unsigned ST_TX_DONE_BIT  = 2;
  localparam int unsigned ST_TX_SKIP_BIT  = 3;
  localparam int unsigned ST_MON_NEW_BIT  = 4;
  localparam int unsigned ST_SLIP_BIT     = 5;
  localparam int unsigned ST_W            = 6;
  localparam logic [5:0]  STAT_RESET      = 6'h00;

  // frame geometry
  localparam int unsigned FRAME_BITS      = 256;
  localparam int unsigned SLOT_BITS       = 8;
  localparam int unsigned POS_W           = 8;
  localparam logic [2:0]  SLOT_LAST_BIT   = 3'h7;
  localparam logic [7:0]  POS_FIRST       = 8'h00;
  localparam logic [7:0]  POS_STEP        = 8'h01;

  // elastic store pointers count bits over a two-frame store
  localparam int unsigned PTR_W           = 9;
  localparam logic [8:0]  HALF_FRAME_SEP  = 9'h080;

  typedef logic [PTR_W-1:0] rdm_ptr_t;

  typedef struct packed {
    rdm_ptr_t wr_ptr;
    rdm_ptr_t rd_ptr;
  } rdm_ptr_pair_t;

  typedef struct packed {
    logic     load;
    rdm_ptr_t rd_ptr;
  } rdm_align_cmd_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic frame_start;
  } rdm_rx_bit_t;

  typedef enum logic {APB_IDLE, APB_RESP} rdm_apb_state_t;

endpackage : rdm_pkg
